// ===== common/sutx_pkg.sv
// Package for the serial unit: register offsets, field positions, reset values, timing.
// Assumes a byte-wide register port and a single system clock.
package sutx_pkg;
  localparam int unsigned ADDR_W = 16;
  // Register offsets
  localparam logic [15:0] OFS_PORT_CTRL = 16'hff91;
  localparam logic [15:0] OFS_MODE = 16'hff98;
  localparam logic [15:0] OFS_BIT_RATE = 16'hff99;
  localparam logic [15:0] OFS_CONTROL = 16'hff9a;
  localparam logic [15:0] OFS_TX_DATA = 16'hff9b;
  localparam logic [15:0] OFS_STATUS = 16'hff9c;
  localparam logic [15:0] OFS_RX_DATA = 16'hff9d;
  // Port control fields
  localparam int unsigned PC_TX_PIN_FUNC = 4;
  localparam int unsigned PC_TX_INVERT = 1;
  // Mode fields
  localparam int unsigned MD_COMM = 7;
  localparam int unsigned MD_CHAR_LEN = 6;
  localparam int unsigned MD_PAR_EN = 5;
  localparam int unsigned MD_PAR_ODD = 4;
  localparam int unsigned MD_STOP = 3;
  localparam int unsigned MD_MULTIPROC = 2;
  // Control fields
  localparam int unsigned CT_TX_IE = 7;
  localparam int unsigned CT_RX_IE = 6;
  localparam int unsigned CT_TX_EN = 5;
  localparam int unsigned CT_RX_EN = 4;
  localparam int unsigned CT_TX_END_FLAG_IE = 2;
  // Status fields
  localparam int unsigned ST_TX_EMPTY = 7;
  localparam int unsigned ST_RX_FULL = 6;
  localparam int unsigned ST_OVERRUN = 5;
  localparam int unsigned ST_FRAMING = 4;
  localparam int unsigned ST_PARITY = 3;
  localparam int unsigned ST_TX_END = 2;
  localparam int unsigned ST_MP_RX = 1;
  localparam int unsigned ST_MP_TX = 0;
  // Reset values
  localparam logic [7:0] RST_PORT_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BIT_RATE = 8'hff;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TX_DATA = 8'hff;
  // Sixteen baud ticks per bit
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sutx_req_t;
  // Interrupt request lines
  typedef struct packed {
    logic tx_end_irq;
    logic tx_empty_irq;
    logic rx_full_irq;
    logic rx_error_irq;
  } sutx_irq_t;
endpackage : sutx_pkg

// ===== src/sutx_serial_unit.sv
// Asynchronous serial unit with multiprocessor framing, byte register port.
// Assumes one 10 MHz clock; rx pin is asynchronous and is synchronised here.
module sutx_serial_unit
  import sutx_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire sutx_req_t req,
  output logic [7:0] rdata,
  // Serial pins
  output logic serial_tx_pin,
  output logic serial_tx_pin_oe,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic serial_rx_pin,
  // Interrupts
  output sutx_irq_t irq,
  output logic serial_unit_irq
);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_MPB, TX_PAR, TX_STOP} sutx_txst_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_MPB, RX_PAR, RX_STOP} sutx_rxst_t;

  logic [7:0] port_ctrl_ff, mode_ff, bit_rate_ff, control_ff, tx_data_ff, rx_data_ff;
  logic tx_empty_ff, tx_end_ff, rx_full_ff, overrun_ff, framing_ff, parity_ff;
  logic mp_rx_ff, mp_tx_ff;
  logic [7:0] rdata_ff;
  logic [5:0] pre_ff;
  logic [7:0] brg_ff;
  logic tick;
  sutx_txst_t tx_st_ff;
  logic [3:0] tx_sub_ff;
  logic [2:0] tx_bit_ff;
  logic [DATA_W-1:0] tx_sh_ff;
  logic tx_mp_ff, tx_par_ff, tx_stop2_ff, tx_line_ff;
  sutx_rxst_t rx_st_ff;
  logic [3:0] rx_sub_ff;
  logic [2:0] rx_bit_ff;
  logic [DATA_W-1:0] rx_sh_ff;
  logic rx_par_ff, rx_mp_ff;
  logic [2:0] rx_sync_ff;
  logic rx_level_ff;

  wire wr_any = ce & req.wr;
  wire rd_any = ce & req.rd;
  wire tx_en = control_ff[CT_TX_EN];
  wire rx_en = control_ff[CT_RX_EN];
  wire async_mode = ~mode_ff[MD_COMM];
  wire [2:0] last_bit = (async_mode && mode_ff[MD_CHAR_LEN]) ? 3'd6 : 3'd7;
  wire mp_mode = mode_ff[MD_MULTIPROC];
  wire par_on = mode_ff[MD_PAR_EN] & ~mp_mode;
  wire tx_data_wr = wr_any && req.addr == OFS_TX_DATA;
  wire status_wr = wr_any && req.addr == OFS_STATUS;
  logic tx_last_done, rx_done, rx_ferr, rx_perr;
  wire load_tsr = ce && tick && tx_en && !tx_empty_ff && (tx_st_ff == TX_IDLE || tx_last_done);

  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_ctrl_ff <= RST_PORT_CTRL;
      mode_ff <= RST_MODE;
      bit_rate_ff <= RST_BIT_RATE;
      control_ff <= RST_CONTROL;
      tx_data_ff <= RST_TX_DATA;
      mp_tx_ff <= 1'b0;
    end else if (wr_any) begin
      case (req.addr)
        OFS_PORT_CTRL: port_ctrl_ff <= req.wdata;
        OFS_MODE: mode_ff <= req.wdata;
        OFS_BIT_RATE: bit_rate_ff <= req.wdata;
        OFS_CONTROL: control_ff <= req.wdata;
        OFS_TX_DATA: tx_data_ff <= req.wdata;
        OFS_STATUS: mp_tx_ff <= req.wdata[ST_MP_TX];
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (rd_any) begin
      case (req.addr)
        OFS_PORT_CTRL: rdata_ff <= port_ctrl_ff;
        OFS_MODE: rdata_ff <= mode_ff;
        OFS_BIT_RATE: rdata_ff <= bit_rate_ff;
        OFS_CONTROL: rdata_ff <= control_ff;
        OFS_TX_DATA: rdata_ff <= tx_data_ff;
        OFS_STATUS: rdata_ff <= {tx_empty_ff, rx_full_ff, overrun_ff, framing_ff, parity_ff,
                                 tx_end_ff, mp_rx_ff, mp_tx_ff};
        OFS_RX_DATA: rdata_ff <= rx_data_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end else if (ce) begin
      rdata_ff <= 8'h00;
    end
  end
  assign rdata = rdata_ff;

  // Prescaler: 00 undivided, 01 /4, 10 /16, 11 /64
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 6'h00;
    end else if (ce) begin
      pre_ff <= pre_ff + 6'h01;
    end
  end
  logic pre_tick;
  always_comb begin
    case (mode_ff[1:0])
      2'b00: pre_tick = 1'b1;
      2'b01: pre_tick = pre_ff[1:0] == 2'b11;
      2'b10: pre_tick = pre_ff[3:0] == 4'hf;
      default: pre_tick = pre_ff == 6'h3f;
    endcase
  end

  // Divide by bit rate value plus one; internal generator only
  // Each tick is one sixteenth of a bit, so rate = clk / (16 * 2 * prescale * (N+1)) via toggle
  logic half_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brg_ff <= 8'h00;
      half_ff <= 1'b0;
    end else if (ce && pre_tick) begin
      if (brg_ff >= bit_rate_ff) begin
        brg_ff <= 8'h00;
        half_ff <= ~half_ff;
      end else begin
        brg_ff <= brg_ff + 8'h01;
      end
    end
  end
  assign tick = pre_tick && brg_ff >= bit_rate_ff && half_ff;

  // Transmit engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_ff <= TX_IDLE;
      tx_sub_ff <= 4'h0;
      tx_bit_ff <= 3'd0;
      tx_sh_ff <= '1;
      tx_mp_ff <= 1'b0;
      tx_par_ff <= 1'b0;
      tx_stop2_ff <= 1'b0;
      tx_line_ff <= 1'b1;
    end else if (ce && tick) begin
      tx_sub_ff <= tx_sub_ff + 4'h1;
      case (tx_st_ff)
        TX_IDLE: begin
          tx_line_ff <= 1'b1;
          tx_sub_ff <= 4'h0;
        end
        TX_START: if (tx_sub_ff == 4'hf) begin
          tx_line_ff <= tx_sh_ff[0];
          tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
          tx_sh_ff <= {1'b1, tx_sh_ff[DATA_W-1:1]};
          tx_st_ff <= TX_DATA;
        end
        TX_DATA: if (tx_sub_ff == 4'hf) begin
          tx_bit_ff <= tx_bit_ff + 3'd1;
          if (tx_bit_ff == last_bit) begin
            // Multiprocessor bit after data; ID or data frame
            if (mp_mode) begin
              tx_line_ff <= tx_mp_ff;
              tx_st_ff <= TX_MPB;
            end else if (par_on) begin
              tx_line_ff <= tx_par_ff;
              tx_st_ff <= TX_PAR;
            end else begin
              tx_line_ff <= 1'b1;
              tx_st_ff <= TX_STOP;
            end
          end else begin
            tx_line_ff <= tx_sh_ff[0];
            tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
            tx_sh_ff <= {1'b1, tx_sh_ff[DATA_W-1:1]};
          end
        end
        TX_MPB, TX_PAR: if (tx_sub_ff == 4'hf) begin
          tx_line_ff <= 1'b1;
          tx_st_ff <= TX_STOP;
        end
        TX_STOP: if (tx_sub_ff == 4'hf) begin
          if (mode_ff[MD_STOP] && !tx_stop2_ff) begin
            tx_stop2_ff <= 1'b1;
          end else begin
            tx_st_ff <= TX_IDLE;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
      // Buffer moves in when idle or right after the last stop bit, no idle tick between frames
      if (load_tsr) begin
        tx_sh_ff <= tx_data_ff[DATA_W-1:0];
        tx_mp_ff <= mp_tx_ff;
        tx_par_ff <= mode_ff[MD_PAR_ODD];
        tx_stop2_ff <= 1'b0;
        tx_bit_ff <= 3'd0;
        tx_sub_ff <= 4'h0;
        tx_line_ff <= 1'b0;
        tx_st_ff <= TX_START;
      end
    end
  end
  assign tx_last_done = ce && tick && tx_st_ff == TX_STOP && tx_sub_ff == 4'hf &&
                        !(mode_ff[MD_STOP] && !tx_stop2_ff);

  // Transmit flags; the empty set on load wins over a software clear, and a software clear wins over the end set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_empty_ff <= 1'b1;
      tx_end_ff <= 1'b1;
    end else if (ce) begin
      if (!tx_en) begin
        tx_empty_ff <= 1'b1;
        tx_end_ff <= 1'b1;
      end else if (load_tsr) begin
        tx_empty_ff <= 1'b1;
      end else if (tx_data_wr || (status_wr && !req.wdata[ST_TX_EMPTY])) begin
        tx_empty_ff <= 1'b0;
        tx_end_ff <= 1'b0;
      end else if (tx_last_done && tx_empty_ff) begin
        tx_end_ff <= 1'b1;
      end
    end
  end

  // Receive pin: three flops, change accepted when last two agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync_ff <= 3'b111;
      rx_level_ff <= 1'b1;
    end else if (ce) begin
      rx_sync_ff <= {rx_sync_ff[1:0], serial_rx_pin};
      if (rx_sync_ff[1] == rx_sync_ff[2]) begin
        rx_level_ff <= rx_sync_ff[2];
      end
    end
  end

  // Receive engine, samples mid bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_ff <= RX_IDLE;
      rx_sub_ff <= 4'h0;
      rx_bit_ff <= 3'd0;
      rx_sh_ff <= '0;
      rx_par_ff <= 1'b0;
      rx_mp_ff <= 1'b0;
    end else if (ce && tick) begin
      rx_sub_ff <= rx_sub_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE: begin
          rx_sub_ff <= 4'h0;
          if (rx_en && !rx_level_ff && async_mode) begin
            rx_st_ff <= RX_START;
          end
        end
        RX_START: if (rx_sub_ff == MID_SAMPLE) begin
          rx_sub_ff <= 4'h0;
          rx_bit_ff <= 3'd0;
          rx_par_ff <= mode_ff[MD_PAR_ODD];
          rx_st_ff <= rx_level_ff ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_sub_ff == 4'hf) begin
          rx_sh_ff <= {rx_level_ff, rx_sh_ff[DATA_W-1:1]};
          rx_par_ff <= rx_par_ff ^ rx_level_ff;
          rx_bit_ff <= rx_bit_ff + 3'd1;
          if (rx_bit_ff == last_bit) begin
            rx_st_ff <= mp_mode ? RX_MPB : (par_on ? RX_PAR : RX_STOP);
          end
        end
        RX_MPB: if (rx_sub_ff == 4'hf) begin
          rx_mp_ff <= rx_level_ff;
          rx_st_ff <= RX_STOP;
        end
        RX_PAR: if (rx_sub_ff == 4'hf) begin
          rx_par_ff <= rx_par_ff ^ rx_level_ff;
          rx_st_ff <= RX_STOP;
        end
        // Only the first stop bit is checked
        RX_STOP: if (rx_sub_ff == 4'hf) begin
          rx_st_ff <= RX_IDLE;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end
  assign rx_done = ce && tick && rx_st_ff == RX_STOP && rx_sub_ff == 4'hf;
  assign rx_ferr = !rx_level_ff;
  assign rx_perr = par_on && rx_par_ff;
  wire [7:0] rx_word = (last_bit == 3'd6) ? {1'b0, rx_sh_ff[DATA_W-1:1]} : rx_sh_ff;

  // Receive flags; set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_ff <= 8'h00;
      rx_full_ff <= 1'b0;
      overrun_ff <= 1'b0;
      framing_ff <= 1'b0;
      parity_ff <= 1'b0;
      mp_rx_ff <= 1'b0;
    end else if (ce) begin
      if (status_wr) begin
        if (!req.wdata[ST_RX_FULL]) rx_full_ff <= 1'b0;
        if (!req.wdata[ST_OVERRUN]) overrun_ff <= 1'b0;
        if (!req.wdata[ST_FRAMING]) framing_ff <= 1'b0;
        if (!req.wdata[ST_PARITY]) parity_ff <= 1'b0;
      end else if (rd_any && req.addr == OFS_RX_DATA) begin
        rx_full_ff <= 1'b0;
      end
      if (rx_done) begin
        if (rx_full_ff && !(rd_any && req.addr == OFS_RX_DATA)) begin
          overrun_ff <= 1'b1;
        end else if (rx_ferr) begin
          framing_ff <= 1'b1;
          rx_data_ff <= rx_word;
        end else begin
          rx_data_ff <= rx_word;
          mp_rx_ff <= rx_mp_ff;
          if (rx_perr) parity_ff <= 1'b1;
          else rx_full_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_tx_pin <= 1'b1;
      serial_tx_pin_oe <= 1'b0;
    end else if (ce) begin
      if (port_ctrl_ff[PC_TX_PIN_FUNC]) begin
        serial_tx_pin <= tx_line_ff ^ port_ctrl_ff[PC_TX_INVERT];
        serial_tx_pin_oe <= 1'b1;
      end else begin
        serial_tx_pin <= gpio_out;
        serial_tx_pin_oe <= gpio_oe;
      end
    end
  end

  assign irq.tx_empty_irq = tx_empty_ff & control_ff[CT_TX_IE];
  assign irq.tx_end_irq = tx_end_ff & control_ff[CT_TX_END_FLAG_IE];
  assign irq.rx_full_irq = rx_full_ff & control_ff[CT_RX_IE];
  assign irq.rx_error_irq = (overrun_ff | framing_ff | parity_ff) & control_ff[CT_RX_IE];
  assign serial_unit_irq = |irq;

endmodule : sutx_serial_unit

// ===== verif/sutx_chk.sv
// Checker for the serial unit: register port, pin and interrupt relations.
// Assumes it is bound to sutx_serial_unit and sees only its ports.
module sutx_chk
  import sutx_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire sutx_req_t req,
  input wire logic [7:0] rdata,
  // Pins
  input wire logic serial_tx_pin,
  input wire logic serial_tx_pin_oe,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic serial_rx_pin,
  // Interrupts
  input wire sutx_irq_t irq,
  input wire logic serial_unit_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pc_ff, md_ff, br_ff, ct_ff;
  logic te;
  assign te = ct_ff[CT_TX_EN];
  // Shadows follow software writes so checks need no view inside
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_ff <= RST_PORT_CTRL;
      md_ff <= RST_MODE;
      br_ff <= RST_BIT_RATE;
      ct_ff <= RST_CONTROL;
    end else if (ce && req.wr) begin
      if (req.addr == OFS_PORT_CTRL) pc_ff <= req.wdata;
      if (req.addr == OFS_MODE) md_ff <= req.wdata;
      if (req.addr == OFS_BIT_RATE) br_ff <= req.wdata;
      if (req.addr == OFS_CONTROL) ct_ff <= req.wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rate_rd_s;
    ce && req.rd && req.addr == OFS_BIT_RATE;
  endsequence
  sequence tx_go_s;
    ce && req.wr && req.addr == OFS_TX_DATA && te && pc_ff == 8'h10 && br_ff == 8'h00 && md_ff[1:0] == 2'b00;
  endsequence
  property rate_back_p;
    logic [7:0] d;
    (ce && req.wr && req.addr == OFS_BIT_RATE, d = req.wdata) ##1 rate_rd_s |=> rdata == d;
  endproperty
  irq_or_a: assert property (serial_unit_irq ==
      (irq.tx_end_irq | irq.tx_empty_irq | irq.rx_full_irq | irq.rx_error_irq))
    else $error("shared request differs from sources");
  rate_back_a: assert property (rate_back_p)
    else $error("bit rate readback wrong");
  empty_mask_a: assert property (!ct_ff[CT_TX_IE] |-> !irq.tx_empty_irq)
    else $error("empty request while disabled");
  end_mask_a: assert property (!ct_ff[CT_TX_END_FLAG_IE] |-> !irq.tx_end_irq)
    else $error("end request while disabled");
  rx_mask_a: assert property (!ct_ff[CT_RX_IE] |-> !(irq.rx_full_irq || irq.rx_error_irq))
    else $error("rx request while disabled");
  empty_held_a: assert property (!te && !$past(te) && ct_ff[CT_TX_IE] |-> irq.tx_empty_irq)
    else $error("empty flag not held while tx off");
  end_held_a: assert property (!te && !$past(te) && ct_ff[CT_TX_END_FLAG_IE] |-> irq.tx_end_irq)
    else $error("end flag not held while tx off");
  tx_start_a: assert property (tx_go_s |-> ##[1:800] !serial_tx_pin)
    else $error("no start bit after data write");
  tx_idle_a: assert property (pc_ff == 8'h10 && $past(pc_ff) == 8'h10 && !te && !$past(te, 2) |-> serial_tx_pin)
    else $error("line not idle high");
  pin_func_a: assert property (pc_ff[PC_TX_PIN_FUNC] && $past(pc_ff[PC_TX_PIN_FUNC]) |-> serial_tx_pin_oe)
    else $error("pin not driven in serial function");
  gpio_a: assert property (!pc_ff[PC_TX_PIN_FUNC] && !$past(pc_ff[PC_TX_PIN_FUNC]) |->
      serial_tx_pin_oe == $past(gpio_oe) && (!$past(gpio_oe) || serial_tx_pin == $past(gpio_out)))
    else $error("general pin path wrong");
endmodule : sutx_chk

bind sutx_serial_unit sutx_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk), .rst(rst), .ce(ce), .req(req),
  .rdata(rdata), .serial_tx_pin(serial_tx_pin), .serial_tx_pin_oe(serial_tx_pin_oe), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .serial_rx_pin(serial_rx_pin), .irq(irq), .serial_unit_irq(serial_unit_irq));

// ===== verif/sutx_far_station.sv
// Far station on the shared line: samples frames and sends frames.
// Assumes an idle-high line and a fixed bit length in clocks.
module sutx_far_station #(
  parameter int BIT_CLKS = 32
) (
  // Clock and line
  input wire logic clk,
  input wire logic line,
  input wire logic [3:0] nbits,
  output logic rx_line,
  // Capture results
  output logic [15:0] frame_prev,
  output logic [15:0] frame_last,
  output logic [15:0] gap,
  output logic [7:0] count,
  output logic stop_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cyc = '0;
  logic [15:0] t_last;
  logic [15:0] bits;
  always @(posedge clk) cyc <= cyc + 16'd1;
  // low start, LSB first, mp bit, high stop
  initial begin
    count = '0;
    rx_line = 1'b1;
    t_last = '0;
    forever begin
      @(negedge line);
      gap = cyc - t_last;
      t_last = cyc;
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (line == 1'b0) begin
        bits = '0;
        for (int i = 0; i < nbits; i++) begin
          repeat (BIT_CLKS) @(posedge clk);
          bits[i] = line;
        end
        repeat (BIT_CLKS) @(posedge clk);
        stop_ok = line;
        frame_prev = frame_last;
        frame_last = bits;
        count = count + 8'd1;
      end
    end
  end
  // sends LSB first, then releases the line high
  task automatic send(input logic [15:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      rx_line <= b[k];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask : send
endmodule : sutx_far_station

// ===== verif/sutx_serial_unit_tb.sv
// Testbench for the serial unit: registers, framing, interrupts, pin.
// Assumes the far station model and the bound checker are compiled.
module sutx_serial_unit_tb
  import sutx_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, ce, gpio_out, gpio_oe, rx_line, tx_pin, tx_oe, line, unit_irq, stop_ok;
  sutx_req_t req;
  sutx_irq_t irq;
  logic [7:0] rdata, d, md, n0, nfr;
  logic [15:0] fr_prev, fr_last, gap;
  logic [3:0] nbits;
  logic [7:0] md_tab [4] = '{8'h04, 8'h2c, 8'h44, 8'h20};
  int errors, compares, k;
  // Released pin reads high through the pull-up
  assign line = (tx_oe === 1'b1) ? tx_pin : 1'b1;
  sutx_serial_unit dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata), .serial_tx_pin(tx_pin),
    .serial_tx_pin_oe(tx_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .serial_rx_pin(rx_line),
    .irq(irq), .serial_unit_irq(unit_irq));
  sutx_far_station #(.BIT_CLKS(32)) far (.clk(clk), .line(line), .nbits(nbits), .rx_line(rx_line),
    .frame_prev(fr_prev), .frame_last(fr_last), .gap(gap), .count(nfr), .stop_ok(stop_ok));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req <= '{a, v, 1'b0, 1'b0};
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b0};
    #1 v = rdata;
  endtask : rd
  // Write then read with no gap between the strobes
  task automatic wrrd(input logic [15:0] a, input logic [7:0] v, output logic [7:0] q);
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req <= '{a, v, 1'b0, 1'b1};
    @(posedge clk);
    req <= '{a, v, 1'b0, 1'b0};
    #1 q = rdata;
  endtask : wrrd
  task automatic wait_st(input logic [7:0] m);
    int n = 0;
    d = 8'h00;
    while ((d & m) !== m && n < 200) begin
      rd(OFS_STATUS, d);
      n++;
    end
    chk8(d & m, m);
  endtask : wait_st
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    gpio_out = 1'b0;
    gpio_oe = 1'b0;
    req = '0;
    errors = 0;
    compares = 0;
    nbits = 4'd9;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_PORT_CTRL, d); chk8(d, RST_PORT_CTRL);
    rd(OFS_MODE, d); chk8(d, RST_MODE);
    rd(OFS_BIT_RATE, d); chk8(d, 8'hff);
    rd(OFS_CONTROL, d); chk8(d, RST_CONTROL);
    rd(16'hff90, d); chk8(d, 8'h00);
    wr(OFS_TX_DATA, 8'h11);
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, d); chk8(d & 8'hfc, 8'h84);
    wr(OFS_CONTROL, 8'h84);
    @(negedge clk);
    chk1(irq.tx_empty_irq, 1'b1);
    chk1(irq.tx_end_irq, 1'b1);
    chk1(unit_irq, 1'b1);
    wr(OFS_CONTROL, 8'h00);
    @(negedge clk);
    chk1(unit_irq, 1'b0);
    // A frozen block must ignore the strobe
    ce <= 1'b0;
    wr(OFS_BIT_RATE, 8'h33);
    ce <= 1'b1;
    rd(OFS_BIT_RATE, d); chk8(d, 8'hff);
    wrrd(OFS_BIT_RATE, 8'h00, d); chk8(d, 8'h00);
    wr(OFS_PORT_CTRL, 8'h10);
    for (int t = 0; t < 4; t++) begin
      md = md_tab[t];
      nbits = md[6] ? 4'd8 : 4'd9;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_MODE, md);
      wr(OFS_CONTROL, 8'h20);
      wr(OFS_STATUS, 8'h85);
      n0 = nfr;
      wr(OFS_TX_DATA, 8'h01);
      wait_st(8'h80);
      wr(OFS_STATUS, 8'h84);
      wr(OFS_TX_DATA, 8'hb8);
      for (k = 0; k < 1500 && nfr != n0 + 8'd2; k++) @(posedge clk);
      chk8(nfr, n0 + 8'd2);
      chk16(fr_prev, (16'h0001 << (nbits - 4'd1)) | 16'h0001);
      chk16(fr_last, {8'h00, 8'hb8 & (md[6] ? 8'h7f : 8'hff)});
      chk16(gap, 16'(32 * (nbits + 2 + md[3])));
      chk1(stop_ok, 1'b1);
      wait_st(8'h04);
    end
    wr(OFS_CONTROL, 8'h24);
    @(negedge clk);
    chk1(irq.tx_end_irq, 1'b1);
    chk1(irq.tx_empty_irq, 1'b0);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_MODE, 8'h04);
    wr(OFS_CONTROL, 8'h50);
    far.send({5'h1f, 1'b0, 8'h5a, 1'b0}, 11);
    wait_st(8'h40);
    chk1(irq.rx_full_irq, 1'b1);
    rd(OFS_RX_DATA, d); chk8(d, 8'h5a);
    rd(OFS_STATUS, d); chk8(d & 8'h40, 8'h00);
    // Low stop bit must flag a framing fault
    far.send({5'h00, 1'b0, 8'ha5, 1'b0}, 11);
    wait_st(8'h10);
    chk1(irq.rx_error_irq, 1'b1);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_PORT_CTRL, 8'h12);
    repeat (2) @(negedge clk);
    chk1(tx_pin, 1'b0);
    @(posedge clk);
    gpio_oe <= 1'b1;
    wr(OFS_PORT_CTRL, 8'h00);
    repeat (2) @(negedge clk);
    chk1(tx_oe, 1'b1);
    chk1(tx_pin, 1'b0);
    @(posedge clk);
    gpio_out <= 1'b1;
    repeat (2) @(negedge clk);
    chk1(tx_pin, 1'b1);
    conclude();
  end
  // Whole run needs well under this span
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : sutx_serial_unit_tb
